// ---- hw/rsq_pkg.sv ----
package rsq_pkg;
  // Register indices on the plain register port.
  localparam logic [7:0] REG_MODEM_CONFIG_TWO = 8'h00;
  localparam logic [7:0] REG_PACKET_CTRL = 8'h01;
  localparam logic [7:0] REG_DEVIATION = 8'h02;
  localparam logic [7:0] REG_AGC_CTRL = 8'h03;
  localparam logic [7:0] REG_GAIN_CEILING = 8'h04;
  localparam logic [7:0] REG_CARRIER_BASE = 8'h05;
  localparam logic [7:0] REG_PIN_SELECT = 8'h06;
  localparam logic [7:0] REG_ASK_DEPTH = 8'h07;
  localparam logic [7:0] REG_ASK_SHAPE = 8'h08;
  localparam logic [7:0] REG_RSSI = 8'h10;
  localparam logic [7:0] REG_PACKET_STATUS = 8'h11;
  localparam logic [7:0] REG_PQ_COUNT = 8'h12;
  // Reset values of the writable registers.
  localparam logic [7:0] RST_MODEM_CONFIG_TWO = 8'h02;
  localparam logic [7:0] RST_PACKET_CTRL = 8'h08;
  localparam logic [7:0] RST_DEVIATION = 8'h07;
  localparam logic [7:0] RST_AGC_CTRL = 8'h01;
  localparam logic [7:0] RST_GAIN_CEILING = 8'h03;
  localparam logic [7:0] RST_CARRIER_BASE = 8'h60;
  localparam logic [7:0] RST_PIN_SELECT = 8'h0E;
  localparam logic [7:0] RST_ASK_DEPTH = 8'h00;
  localparam logic [7:0] RST_ASK_SHAPE = 8'h00;
  // Modulation format codes in modem_config_two[6:4].
  localparam logic [2:0] FMT_FSK = 3'h0;
  localparam logic [2:0] FMT_OOK = 3'h3;
  localparam logic [2:0] FMT_ASK = 3'h4;
  localparam logic [2:0] FMT_MSK = 3'h7;
  // Output pin select codes.
  localparam logic [5:0] PIN_SEL_PQ_REACHED = 6'h08;
  localparam logic [5:0] PIN_SEL_CARRIER = 6'h0E;
  // Preamble quality counter steps and threshold scale.
  localparam logic [7:0] PQ_UP_STEP = 8'h01;
  localparam logic [7:0] PQ_DOWN_STEP = 8'h08;
  localparam int PQ_THRESHOLD_SCALE = 4;
  // Relative carrier steps in half-dB units: 6, 10 and 14 dB.
  localparam logic [7:0] REL_STEP_6DB = 8'h0C;
  localparam logic [7:0] REL_STEP_10DB = 8'h14;
  localparam logic [7:0] REL_STEP_14DB = 8'h1C;
  // Sync correlator error budgets.
  localparam logic [5:0] SYNC16_SOFT_ERRS = 6'h01;
  localparam logic [5:0] SYNC32_SOFT_ERRS = 6'h02;
  // Full amplitude for a one symbol in ASK.
  localparam logic [7:0] ASK_FULL_LEVEL = 8'hFF;
endpackage

// ---- hw/rsq_top.sv ----
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module rsq_top
  import rsq_pkg::*;
#(
  parameter int PQ_WIDTH = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Receive chain inputs.
  input wire logic rx_enter,
  input wire logic rx_active,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic sync_check,
  input wire logic [5:0] sync16_errs,
  input wire logic [5:0] sync32_errs,
  input wire logic [7:0] rssi_sample,
  input wire logic rssi_sample_valid,
  input wire logic packet_end,
  // Receive chain outputs.
  output logic sync_found,
  output logic fifo_write_enable,
  output logic status_byte_valid,
  output logic [7:0] status_rssi_byte,
  output logic general_output_pin,
  // Transmit chain.
  input wire logic tx_active,
  input wire logic tx_bit,
  output logic tx_symbol,
  output logic pa_enable,
  output logic [7:0] pa_amplitude,
  output logic [2:0] msk_transition_frac,
  output logic [2:0] front_gain_ceiling,
  output logic [1:0] digital_gain_ceiling,
  output logic [2:0] channel_level_target
);

  // The threshold compare needs room for four times the largest field.
  if (PQ_WIDTH < 5 || PQ_WIDTH > 8) begin : g_check
    $error("PQ_WIDTH must lie between 5 and 8");
  end

  // Whole state of the block.
  typedef struct packed {
    logic [7:0] modem_cfg;
    logic [7:0] pkt_ctrl;
    logic [7:0] deviation;
    logic [7:0] agc_ctrl;
    logic [7:0] gain_ceil;
    logic [7:0] carrier_base;
    logic [7:0] pin_sel;
    logic [7:0] ask_depth;
    logic [7:0] ask_shape;
    logic [7:0] rdata;
    logic [PQ_WIDTH-1:0] pq_count;
    logic last_bit;
    logic have_bit;
    logic sync_locked;
    logic sync_pulse;
    logic [7:0] rssi;
    logic [7:0] prev_rssi;
    logic have_prev;
    logic [7:0] decim;
    logic abs_carrier;
    logic rel_carrier;
    logic status_valid;
    logic [7:0] status_rssi;
    logic tx_sym;
    logic pa_on;
    logic [7:0] amplitude;
    logic pin;
  } rsq_state_t;

  rsq_state_t state_r;
  rsq_state_t state_nxt;

  // Field views of the configuration registers.
  logic [2:0] sync_qualifier_select;
  logic [2:0] mod_format;
  logic [2:0] preamble_quality_threshold;
  logic status_append_enable;
  logic [1:0] rssi_filter_length;
  logic [1:0] relative_cs_step;
  logic [3:0] absolute_cs_level;
  logic [5:0] output_pin_select;
  assign sync_qualifier_select = state_r.modem_cfg[2:0];
  assign mod_format = state_r.modem_cfg[6:4];
  assign preamble_quality_threshold = state_r.pkt_ctrl[2:0];
  assign status_append_enable = state_r.pkt_ctrl[3];
  assign rssi_filter_length = state_r.agc_ctrl[1:0];
  assign relative_cs_step = state_r.agc_ctrl[3:2];
  assign absolute_cs_level = state_r.agc_ctrl[7:4];
  assign output_pin_select = state_r.pin_sel[5:0];

  // Maps the relative step field to a half-dB step, zero when off.
  function automatic logic [7:0] rel_step(input logic [1:0] sel);
    logic [7:0] step;
    unique case (sel)
      2'h1: step = REL_STEP_6DB;
      2'h2: step = REL_STEP_10DB;
      2'h3: step = REL_STEP_14DB;
      default: step = 8'h00;
    endcase
    return step;
  endfunction

  // Derived receive qualifiers.
  logic carrier_sense;
  logic sync_enabled;
  logic [PQ_WIDTH-1:0] pq_limit;
  logic pq_reached;
  logic sync_match;
  logic sync_accept;
  logic [7:0] abs_threshold;
  logic [7:0] decim_limit;

  // Either detector raises carrier sense.
  assign carrier_sense = state_r.abs_carrier | state_r.rel_carrier;
  // Code 000 and 100 run without any sync word search.
  assign sync_enabled = sync_qualifier_select[1:0] != 2'h0;
  // Four times the threshold field; a zero field always passes.
  // The width check above keeps four times seven inside the counter.
  assign pq_limit = PQ_WIDTH'(PQ_THRESHOLD_SCALE * int'(preamble_quality_threshold));
  assign pq_reached = state_r.pq_count >= pq_limit;
  // Threshold is the base level moved by the signed level field in 1 dB.
  assign abs_threshold = 8'(state_r.carrier_base + {{3{absolute_cs_level[3]}}, absolute_cs_level, 1'b0});
  // Every 2^length incoming samples one update is taken.
  assign decim_limit = 8'((9'h001 << rssi_filter_length) - 9'h001);

  // Match requirement chosen by the low two bits of the select.
  always_comb begin
    unique case (sync_qualifier_select[1:0])
      2'h1: sync_match = sync16_errs <= SYNC16_SOFT_ERRS;
      2'h2: sync_match = sync16_errs == 6'h00;
      2'h3: sync_match = sync32_errs <= SYNC32_SOFT_ERRS;
      default: sync_match = 1'b0;
    endcase
  end

  // Upper codes add the carrier sense condition to the search.
  // A locked search ignores further checks until the next receive entry.
  assign sync_accept = sync_check & sync_match & rx_active & ~state_r.sync_locked
    & (~sync_qualifier_select[2] | carrier_sense)
    & pq_reached;

  // Next-state logic for the whole block.
  always_comb begin
    logic [7:0] step;
    logic [7:0] diff_up;
    logic [7:0] diff_dn;
    logic [7:0] target;
    step = rel_step(relative_cs_step);
    diff_up = 8'h00;
    diff_dn = 8'h00;
    target = 8'h00;
    state_nxt = state_r;
    state_nxt.sync_pulse = 1'b0;
    state_nxt.status_valid = 1'b0;
    state_nxt.rdata = 8'h00;

    // Register writes.
    if (reg_write) begin
      unique case (reg_addr)
        REG_MODEM_CONFIG_TWO: state_nxt.modem_cfg = reg_wdata & 8'h77;
        REG_PACKET_CTRL: state_nxt.pkt_ctrl = reg_wdata & 8'h0F;
        REG_DEVIATION: state_nxt.deviation = reg_wdata & 8'h07;
        REG_AGC_CTRL: state_nxt.agc_ctrl = reg_wdata;
        REG_GAIN_CEILING: state_nxt.gain_ceil = reg_wdata;
        REG_CARRIER_BASE: state_nxt.carrier_base = reg_wdata;
        REG_PIN_SELECT: state_nxt.pin_sel = reg_wdata & 8'h3F;
        REG_ASK_DEPTH: state_nxt.ask_depth = reg_wdata;
        REG_ASK_SHAPE: state_nxt.ask_shape = reg_wdata;
        default: begin
          // Writes elsewhere are dropped.
        end
      endcase
    end

    // Register reads answer one cycle later; unmapped reads give zero.
    if (reg_read) begin
      unique case (reg_addr)
        REG_MODEM_CONFIG_TWO: state_nxt.rdata = state_r.modem_cfg;
        REG_PACKET_CTRL: state_nxt.rdata = state_r.pkt_ctrl;
        REG_DEVIATION: state_nxt.rdata = state_r.deviation;
        REG_AGC_CTRL: state_nxt.rdata = state_r.agc_ctrl;
        REG_GAIN_CEILING: state_nxt.rdata = state_r.gain_ceil;
        REG_CARRIER_BASE: state_nxt.rdata = state_r.carrier_base;
        REG_PIN_SELECT: state_nxt.rdata = state_r.pin_sel;
        REG_ASK_DEPTH: state_nxt.rdata = state_r.ask_depth;
        REG_ASK_SHAPE: state_nxt.rdata = state_r.ask_shape;
        REG_RSSI: state_nxt.rdata = state_r.rssi;
        REG_PACKET_STATUS: state_nxt.rdata = {4'h0, state_r.pin, state_r.sync_locked,
                                              pq_reached, carrier_sense};
        REG_PQ_COUNT: state_nxt.rdata = 8'(state_r.pq_count);
        default: state_nxt.rdata = 8'h00;
      endcase
    end

    // Preamble quality estimator on each demodulated bit.
    if (rx_bit_valid && rx_active) begin
      state_nxt.last_bit = rx_bit;
      state_nxt.have_bit = 1'b1;
      if (state_r.have_bit && rx_bit != state_r.last_bit) begin
        // Saturate at the top instead of wrapping.
        if (state_r.pq_count != {PQ_WIDTH{1'b1}}) begin
          state_nxt.pq_count = state_r.pq_count + PQ_WIDTH'(PQ_UP_STEP);
        end
      end else if (state_r.have_bit) begin
        // Floor at zero instead of wrapping.
        if (state_r.pq_count > PQ_WIDTH'(PQ_DOWN_STEP)) begin
          state_nxt.pq_count = state_r.pq_count - PQ_WIDTH'(PQ_DOWN_STEP);
        end else begin
          state_nxt.pq_count = '0;
        end
      end
    end

    // Sync detection locks until the next receive entry.
    if (sync_accept) begin
      state_nxt.sync_locked = 1'b1;
      state_nxt.sync_pulse = 1'b1;
    end

    // RSSI decimation and carrier sense on each kept sample.
    if (rssi_sample_valid && rx_active) begin
      if (state_r.decim >= decim_limit) begin
        state_nxt.decim = 8'h00;
        // Freeze once locked while sync detection is on.
        if (!(sync_enabled && state_r.sync_locked)) begin
          state_nxt.rssi = rssi_sample;
        end
        // Signed compare: readings of 0x80 and above are weak levels, not strong ones.
        // Hysteresis: hold the flag while the sample equals the threshold.
        if ($signed(rssi_sample) > $signed(abs_threshold)) begin
          state_nxt.abs_carrier = 1'b1;
        end else if ($signed(rssi_sample) < $signed(abs_threshold)) begin
          state_nxt.abs_carrier = 1'b0;
        end
        // Relative detector compares consecutive kept samples.
        // The sign test comes first so a wrapped difference cannot fake a step.
        diff_up = 8'(rssi_sample - state_r.prev_rssi);
        diff_dn = 8'(state_r.prev_rssi - rssi_sample);
        if (step == 8'h00) begin
          state_nxt.rel_carrier = 1'b0;
        end else if (state_r.have_prev) begin
          if ($signed(rssi_sample) > $signed(state_r.prev_rssi) && diff_up >= step) begin
            state_nxt.rel_carrier = 1'b1;
          end else if ($signed(rssi_sample) < $signed(state_r.prev_rssi) && diff_dn >= step) begin
            state_nxt.rel_carrier = 1'b0;
          end
        end
        state_nxt.prev_rssi = rssi_sample;
        state_nxt.have_prev = 1'b1;
      end else begin
        state_nxt.decim = state_r.decim + 8'h01;
      end
    end

    // Status byte carries the packet's final RSSI value.
    if (packet_end && status_append_enable) begin
      state_nxt.status_valid = 1'b1;
      state_nxt.status_rssi = (rssi_sample_valid && !(sync_enabled && state_r.sync_locked)
                               && state_r.decim >= decim_limit) ? rssi_sample : state_r.rssi;
    end

    // Receive entry restarts the estimator, sync lock and RSSI freeze.
    if (rx_enter) begin
      state_nxt.pq_count = '0;
      state_nxt.have_bit = 1'b0;
      state_nxt.sync_locked = 1'b0;
      state_nxt.decim = 8'h00;
      state_nxt.have_prev = 1'b0;
      state_nxt.rel_carrier = 1'b0;
      // Entry wins over a sync accepted in the same cycle: no stray pulse.
      state_nxt.sync_pulse = 1'b0;
    end

    // Transmit symbol shaping per modulation format.
    // Every format shows its symbol one cycle after the bit is sampled.
    state_nxt.tx_sym = (mod_format == FMT_MSK) ? ~tx_bit : tx_bit;
    unique case (mod_format)
      FMT_OOK: state_nxt.pa_on = tx_active & tx_bit;
      default: state_nxt.pa_on = tx_active;
    endcase
    // ASK ramps toward the one or zero level by the shaping step.
    target = tx_bit ? ASK_FULL_LEVEL : state_r.ask_depth;
    if (mod_format != FMT_ASK || state_r.ask_shape == 8'h00) begin
      state_nxt.amplitude = (mod_format == FMT_ASK) ? target : ASK_FULL_LEVEL;
    end else if (state_r.amplitude < target) begin
      state_nxt.amplitude = (8'(target - state_r.amplitude) > state_r.ask_shape)
                            ? 8'(state_r.amplitude + state_r.ask_shape) : target;
    end else if (state_r.amplitude > target) begin
      state_nxt.amplitude = (8'(state_r.amplitude - target) > state_r.ask_shape)
                            ? 8'(state_r.amplitude - state_r.ask_shape) : target;
    end

    // Output pin multiplexer.
    unique case (output_pin_select)
      PIN_SEL_PQ_REACHED: state_nxt.pin = pq_reached;
      PIN_SEL_CARRIER: state_nxt.pin = carrier_sense;
      default: state_nxt.pin = 1'b0;
    endcase
  end

  // State register.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // Configuration returns to its power-up values; counters and flags clear.
      state_r <= '0;
      state_r.modem_cfg <= RST_MODEM_CONFIG_TWO;
      state_r.pkt_ctrl <= RST_PACKET_CTRL;
      state_r.deviation <= RST_DEVIATION;
      state_r.agc_ctrl <= RST_AGC_CTRL;
      state_r.gain_ceil <= RST_GAIN_CEILING;
      state_r.carrier_base <= RST_CARRIER_BASE;
      state_r.pin_sel <= RST_PIN_SELECT;
      state_r.ask_depth <= RST_ASK_DEPTH;
      state_r.ask_shape <= RST_ASK_SHAPE;
      state_r.amplitude <= ASK_FULL_LEVEL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs.
  assign reg_rdata = state_r.rdata;
  assign sync_found = state_r.sync_pulse;
  // FIFO writes open only after sync when a sync mode is on.
  // Kept combinational so the gate opens in the cycle the lock is seen.
  assign fifo_write_enable = rx_active & (~sync_enabled | state_r.sync_locked);
  assign status_byte_valid = state_r.status_valid;
  assign status_rssi_byte = state_r.status_rssi;
  assign general_output_pin = state_r.pin;
  assign tx_symbol = state_r.tx_sym;
  assign pa_enable = state_r.pa_on;
  assign pa_amplitude = state_r.amplitude;
  assign msk_transition_frac = state_r.deviation[2:0];
  assign front_gain_ceiling = state_r.gain_ceil[2:0];
  assign digital_gain_ceiling = state_r.gain_ceil[4:3];
  assign channel_level_target = state_r.gain_ceil[7:5];

endmodule

// ---- bench/rsq_chk.sv ----
`timescale 1ns/1ns
// Port-level checker for the receive qualifier and transmit shaping block.
module rsq_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Register port.
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Receive side.
  input wire logic rx_enter,
  input wire logic rx_active,
  input wire logic sync_check,
  input wire logic packet_end,
  input wire logic sync_found,
  input wire logic fifo_write_enable,
  input wire logic status_byte_valid,
  input wire logic [7:0] status_rssi_byte,
  // Transmit side.
  input wire logic tx_active,
  input wire logic pa_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // A sync pulse must come from a check taken in receive mode outside an entry cycle.
  sequence s_taken_check;
    $past(sync_check) && $past(rx_active) && !$past(rx_enter);
  endsequence
  // Once locked, no further pulse can appear for two cycles.
  sequence s_quiet;
    !sync_found [*2];
  endsequence
  AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  AST_SYNC_CAUSE: assert property (sync_found |-> s_taken_check)
    else $error("sync pulse without a taken check");
  AST_SYNC_QUIET: assert property (sync_found && !rx_enter |=> s_quiet)
    else $error("sync pulse repeated while locked");
  AST_FIFO_ACTIVE: assert property (fifo_write_enable |-> rx_active)
    else $error("fifo write enabled outside receive");
  AST_FIFO_LOCK: assert property (sync_found && rx_active |-> fifo_write_enable)
    else $error("fifo write not enabled after sync");
  AST_STATUS_CAUSE: assert property (status_byte_valid |-> $past(packet_end))
    else $error("status byte without packet end");
  AST_STATUS_HOLD: assert property (!status_byte_valid |-> $stable(status_rssi_byte))
    else $error("status byte changed without valid");
  AST_PA_ACTIVE: assert property (pa_enable |-> $past(tx_active))
    else $error("amplifier enabled outside transmit");
endmodule

// ---- bench/test_rsq_top.sv ----
`timescale 1ns/1ns
// Self-checking bench driving registers, receive events and transmit bits.
module test_rsq_top;
  import rsq_pkg::*;
  // Event codes for {rx_enter, sync_check, packet_end, rssi_sample_valid, rx_bit_valid}.
  localparam logic [4:0] EV_ENTER = 5'h10, EV_SYNC = 5'h08, EV_END = 5'h04, EV_RSSI = 5'h02, EV_BIT = 5'h01;
  logic clock = 1'b0, reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rssi_sample = 8'h00, reg_rdata, status_rssi_byte, pa_amplitude;
  logic reg_write = 1'b0, reg_read = 1'b0, rx_enter = 1'b0, rx_active = 1'b0, rx_bit = 1'b0;
  logic rx_bit_valid = 1'b0, sync_check = 1'b0, rssi_sample_valid = 1'b0, packet_end = 1'b0;
  logic tx_active = 1'b0, tx_bit = 1'b0;
  logic [5:0] sync16_errs = 6'h00, sync32_errs = 6'h00;
  logic sync_found, fifo_write_enable, status_byte_valid, general_output_pin, tx_symbol, pa_enable;
  logic [2:0] msk_transition_frac, front_gain_ceiling, channel_level_target;
  logic [1:0] digital_gain_ceiling;
  logic [7:0] rd_val;
  logic [19:0] sc;
  logic [23:0] cc;
  logic [27:0] tc;
  int failures = 0;
  int tests_run = 0;
  // Reset addresses and values; sync cases {mode, e16, e32, carrier, expect}.
  logic [7:0] rst_addr [9] = '{REG_MODEM_CONFIG_TWO, REG_PACKET_CTRL, REG_DEVIATION, REG_AGC_CTRL,
    REG_GAIN_CEILING, REG_CARRIER_BASE, REG_PIN_SELECT, REG_ASK_DEPTH, REG_ASK_SHAPE};
  logic [7:0] rst_val [9] = '{RST_MODEM_CONFIG_TWO, RST_PACKET_CTRL, RST_DEVIATION, RST_AGC_CTRL,
    RST_GAIN_CEILING, RST_CARRIER_BASE, RST_PIN_SELECT, RST_ASK_DEPTH, RST_ASK_SHAPE};
  logic [19:0] sync_case [11] = '{20'h11901, 20'h12000, 20'h21000, 20'h20901, 20'h39201, 20'h30300,
    20'h50000, 20'h51011, 20'h60011, 20'h70211, 20'h40010};
  // Carrier cases {agc, sample, expect}: absolute level +1 and -1 dB, then relative steps.
  logic [23:0] cs_case [16] = '{24'h106100, 24'h106301, 24'h106201, 24'h106100, 24'hF05F01, 24'h041000,
    24'h041B00, 24'h042701, 24'h041B00, 24'h0C1000, 24'h0C2C01, 24'h0C1000, 24'h082300, 24'h083701,
    24'h009000, 24'h007001};
  // Transmit cases {format config, bit, symbol, amplifier, amplitude}.
  logic [27:0] tx_case [7] = '{28'h72101FF, 28'h72011FF, 28'h32000FF, 28'h32111FF, 28'h4200140,
    28'h42111FF, 28'h02111FF};

  rsq_top dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_enter(rx_enter),
    .rx_active(rx_active), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .sync_check(sync_check),
    .sync16_errs(sync16_errs), .sync32_errs(sync32_errs), .rssi_sample(rssi_sample),
    .rssi_sample_valid(rssi_sample_valid), .packet_end(packet_end), .sync_found(sync_found),
    .fifo_write_enable(fifo_write_enable), .status_byte_valid(status_byte_valid),
    .status_rssi_byte(status_rssi_byte), .general_output_pin(general_output_pin), .tx_active(tx_active),
    .tx_bit(tx_bit), .tx_symbol(tx_symbol), .pa_enable(pa_enable), .pa_amplitude(pa_amplitude),
    .msk_transition_frac(msk_transition_frac), .front_gain_ceiling(front_gain_ceiling),
    .digital_gain_ceiling(digital_gain_ceiling), .channel_level_target(channel_level_target));

  // Clock of 100 ns period.
  always #50 clock = ~clock;

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // One-cycle register read; the data is taken in the answer cycle.
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pulses receive events for one cycle together with their data.
  task automatic ev(input logic [4:0] p, input logic b, input logic [7:0] s, input logic [5:0] e16,
    input logic [5:0] e32);
    @(posedge clock);
    {rx_enter, sync_check, packet_end, rssi_sample_valid, rx_bit_valid} <= p;
    rx_bit <= b;
    rssi_sample <= s;
    sync16_errs <= e16;
    sync32_errs <= e32;
    @(posedge clock);
    {rx_enter, sync_check, packet_end, rssi_sample_valid, rx_bit_valid} <= 5'h00;
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    close_out();
  end

  // Main sequence of tests.
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    rx_active <= 1'b1;
    tx_active <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(rst_addr[i]);
      chk("reset value", rst_val[i], rd_val);
    end
    rd(8'h20);
    chk("unmapped read", 8'h00, rd_val);
    $display("test registers done");
    wr(REG_AGC_CTRL, 8'h00);
    for (int i = 0; i < 11; i++) begin
      sc = sync_case[i];
      wr(REG_MODEM_CONFIG_TWO, {5'h00, sc[18:16]});
      ev(EV_ENTER, 1'b0, 8'h00, 6'h00, 6'h00);
      ev(EV_RSSI, 1'b0, sc[4] ? 8'h70 : 8'h10, 6'h00, 6'h00);
      ev(EV_SYNC, 1'b0, 8'h00, {2'b00, sc[15:12]}, {2'b00, sc[11:8]});
      chk("sync_found", {7'h00, sc[0]}, {7'h00, sync_found});
      chk("fifo_write_enable", {7'h00, sc[0] | (sc[17:16] == 2'b00)}, {7'h00, fifo_write_enable});
    end
    wr(REG_MODEM_CONFIG_TWO, 8'h00);
    ev(EV_ENTER, 1'b0, 8'h00, 6'h00, 6'h00);
    chk("fifo open without sync", 8'h01, {7'h00, fifo_write_enable});
    $display("test sync modes done");
    wr(REG_PACKET_CTRL, 8'h09);
    wr(REG_PIN_SELECT, {2'b00, PIN_SEL_PQ_REACHED});
    wr(REG_MODEM_CONFIG_TWO, 8'h02);
    ev(EV_ENTER, 1'b0, 8'h00, 6'h00, 6'h00);
    rd(REG_PQ_COUNT);
    chk("quality count after entry", 8'h00, rd_val);
    ev(EV_RSSI, 1'b0, 8'h90, 6'h00, 6'h00);
    for (int i = 0; i < 5; i++) ev(EV_BIT, ~i[0], 8'h00, 6'h00, 6'h00);
    rd(REG_PQ_COUNT);
    chk("quality count", 8'h04, rd_val);
    rd(REG_PACKET_STATUS);
    chk("quality reached bit", 8'h01, {7'h00, rd_val[1]});
    chk("pin quality reached", 8'h01, {7'h00, general_output_pin});
    ev(EV_BIT, 1'b1, 8'h00, 6'h00, 6'h00);
    rd(REG_PQ_COUNT);
    chk("quality count floor", 8'h00, rd_val);
    ev(EV_SYNC, 1'b0, 8'h00, 6'h00, 6'h00);
    chk("sync gated by quality", 8'h00, {7'h00, sync_found});
    for (int i = 0; i < 4; i++) ev(EV_BIT, i[0], 8'h00, 6'h00, 6'h00);
    ev(EV_SYNC, 1'b0, 8'h00, 6'h00, 6'h00);
    chk("sync after quality", 8'h01, {7'h00, sync_found});
    $display("test preamble quality done");
    ev(EV_RSSI, 1'b0, 8'h30, 6'h00, 6'h00);
    rd(REG_RSSI);
    chk("rssi frozen", 8'h90, rd_val);
    ev(EV_END, 1'b0, 8'h00, 6'h00, 6'h00);
    chk("status byte valid", 8'h01, {7'h00, status_byte_valid});
    chk("status rssi byte", 8'h90, status_rssi_byte);
    ev(EV_ENTER, 1'b0, 8'h00, 6'h00, 6'h00);
    ev(EV_RSSI, 1'b0, 8'h30, 6'h00, 6'h00);
    rd(REG_RSSI);
    chk("rssi after entry", 8'h30, rd_val);
    $display("test rssi done");
    wr(REG_PIN_SELECT, {2'b00, PIN_SEL_CARRIER});
    for (int i = 0; i < 16; i++) begin
      cc = cs_case[i];
      wr(REG_AGC_CTRL, cc[23:16]);
      ev(EV_RSSI, 1'b0, cc[15:8], 6'h00, 6'h00);
      rd(REG_PACKET_STATUS);
      chk("carrier sense bit", cc[7:0], {7'h00, rd_val[0]});
    end
    chk("pin carrier sense", 8'h01, {7'h00, general_output_pin});
    wr(REG_AGC_CTRL, 8'h01);
    ev(EV_ENTER, 1'b0, 8'h00, 6'h00, 6'h00);
    ev(EV_RSSI, 1'b0, 8'h22, 6'h00, 6'h00);
    rd(REG_RSSI);
    chk("rssi between kept samples", 8'h70, rd_val);
    ev(EV_RSSI, 1'b0, 8'h24, 6'h00, 6'h00);
    rd(REG_RSSI);
    chk("rssi second sample kept", 8'h24, rd_val);
    $display("test carrier sense done");
    wr(REG_ASK_DEPTH, 8'h40);
    wr(REG_DEVIATION, 8'h03);
    wr(REG_GAIN_CEILING, 8'hAB);
    for (int i = 0; i < 7; i++) begin
      tc = tx_case[i];
      wr(REG_MODEM_CONFIG_TWO, tc[27:20]);
      @(posedge clock);
      tx_bit <= tc[16];
      repeat (2) @(posedge clock);
      #1;
      chk("tx symbol", {7'h00, tc[12]}, {7'h00, tx_symbol});
      chk("amplifier enable", {7'h00, tc[8]}, {7'h00, pa_enable});
      chk("amplitude", tc[7:0], pa_amplitude);
    end
    wr(REG_ASK_SHAPE, 8'h20);
    wr(REG_MODEM_CONFIG_TWO, 8'h42);
    @(posedge clock);
    tx_bit <= 1'b0;
    @(posedge clock);
    #1;
    chk("amplitude ramp first", 8'hDF, pa_amplitude);
    @(posedge clock);
    #1;
    chk("amplitude ramp second", 8'hBF, pa_amplitude);
    chk("transition fraction", 8'h03, {5'h00, msk_transition_frac});
    chk("gain fields", 8'hAB, {channel_level_target, digital_gain_ceiling, front_gain_ceiling});
    $display("test transmit done");
    close_out();
  end
endmodule

bind rsq_top rsq_chk chk_i (.clock(clock), .reset_n(reset_n), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .rx_enter(rx_enter), .rx_active(rx_active), .sync_check(sync_check), .packet_end(packet_end),
  .sync_found(sync_found), .fifo_write_enable(fifo_write_enable), .status_byte_valid(status_byte_valid),
  .status_rssi_byte(status_rssi_byte), .tx_active(tx_active), .pa_enable(pa_enable));
